/* design/rail_seq_pkg.sv */
// Constants and carrier types for the rail sequencing and fault supervision core
package rail_seq_pkg;

    // Clocking: sys_clk period and internal switching tick period
    localparam int CLK_PERIOD_NS = 4;
    localparam int TICK_PERIOD_NS = 4000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

    // Soft-start and fault timing in switching ticks
    localparam int SS_CYCLE_TICKS = 2048;
    localparam int AMP_RESET_SS_CYCLES = 3;
    localparam int FORGIVE_TICKS = 16384;
    localparam int SS_W = 11;
    localparam int FORGIVE_W = 15;
    localparam int TIMER_W = 13;

    // Rail numbering
    localparam int NUM_RAILS = 5;
    localparam int RAIL_MEM = 0;
    localparam int RAIL_CORE = 1;
    localparam int RAIL_TERM = 2;
    localparam int RAIL_DAC = 3;
    localparam int RAIL_MTERM = 4;
    localparam int NUM_RAMPED = 4;
    localparam logic [4:0] UV_MON_MASK = 5'h17;
    localparam logic [4:0] SUSPEND_KEEP_MASK = 5'h01;

    // Fault counter limits
    localparam int FCNT_W = 4;
    localparam logic [3:0] FAULT_LIMIT_COLD = 4'h4;
    localparam logic [3:0] FAULT_LIMIT_RUN = 4'h5;

    // Register map, byte addresses
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_FAULT = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam int CTRL_CLR_BIT = 0;
    localparam int CTRL_HOLD_BIT = 1;
    localparam logic CTRL_HOLD_RESET = 1'b0;

    typedef enum logic [3:0] {
        ST_OFF, ST_AMP_RESET, ST_SEQ_MEM, ST_SEQ_CORE, ST_SEQ_TERM, ST_SEQ_MTERM,
        ST_ACTIVE, ST_SUSPEND, ST_LOCKOUT
    } seq_state_type;

    typedef struct packed {
        logic suspend_sleep_in;
        logic shutdown_sleep_in;
        logic standby_bias_rail;
        logic main_bias_rail;
        logic [4:0] in_reg;
        logic [4:0] uv;
        logic mem_ov;
        logic mterm_ov;
        logic mem_oc;
        logic good_pin;
    } pin_in_type;

endpackage : rail_seq_pkg

/* design/rail_sequencer.sv */
// Sleep-state sequencing, soft-start and fault supervision of five regulators
//
// Operation
// - Start only after both bias detectors good
// - Hold off state until sleep inputs, 12V good
// - Short compensation to feedback three soft-start cycles
// - Soft-start cycle equals 2048 switching ticks
// - Order: memory, core, termination plus DAC, internal
// - Ramp references monotonically up during soft-start
// - Short internal termination reference while disabled
// - Good comparator enabled one cycle after internal
// - Suspend low: keep only memory, good low
// - Suspend rise: wait 12V, reset, resequence
// - Shutdown entry disables all, good low
// - Monitor rails for under, over voltage, overcurrent
// - Overvoltage shuts all down, latched until shutdown
// - Undervoltage or overcurrent disables that rail, counts
// - Cascaded loss of input counts separately
// - Any fault clears forgiveness counter
// - Forgiveness reaching 16384 clears fault counter
// - Shutdown at four faults cold, else five
// - Restart follows order, regulating rails untouched
// - Good output low unless active and regulating
//
// Register access over AHB-Lite and the register offsets were left to the implementer.
module rail_sequencer
    import rail_seq_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES,
    parameter int SS_TICKS = SS_CYCLE_TICKS,
    parameter int FORGIVE_LIMIT = FORGIVE_TICKS
)
(
    input wire logic sys_clk,
    input wire logic rst_b,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Sleep and bias detector pins
    input wire logic suspend_sleep_in,
    input wire logic shutdown_sleep_in,
    input wire logic standby_bias_rail,
    input wire logic main_bias_rail,
    // Rail monitors from the analog comparators
    input wire logic [4:0] rail_in_reg_in,
    input wire logic [4:0] rail_uv_in,
    input wire logic mem_ov_in,
    input wire logic mterm_ov_in,
    input wire logic mem_oc_in,
    // Regulator controls
    output logic [4:0] rail_enable_out,
    output logic [3:0][SS_W-1:0] ss_level_out,
    output logic [1:0] comp_short_out,
    output logic mterm_ref_short_out,
    // Open-drain termination-good pin
    input wire logic term_rail_good_out_i,
    output logic term_rail_good_out_o,
    output logic term_rail_good_out_oe
);

    localparam logic [SS_W-1:0] RAMP_FULL = '1;
    localparam logic [TIMER_W-1:0] AMP_RESET_LAST = TIMER_W'(AMP_RESET_SS_CYCLES * SS_TICKS - 1);
    localparam logic [TIMER_W-1:0] MTERM_LAST = TIMER_W'(SS_TICKS - 1);
    localparam logic [FORGIVE_W-1:0] FORGIVE_LAST = FORGIVE_W'(FORGIVE_LIMIT - 1);
    localparam logic [FORGIVE_W-1:0] FORGIVE_TOP = FORGIVE_W'(FORGIVE_LIMIT);
    localparam int DIV_W = $clog2(TICK_DIV + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);

    // Pin synchronisers
    pin_in_type pin_raw;
    pin_in_type pin_meta_reg;
    pin_in_type pin_reg;

    assign pin_raw = '{suspend_sleep_in: suspend_sleep_in, shutdown_sleep_in: shutdown_sleep_in,
        standby_bias_rail: standby_bias_rail, main_bias_rail: main_bias_rail,
        in_reg: rail_in_reg_in, uv: rail_uv_in, mem_ov: mem_ov_in, mterm_ov: mterm_ov_in,
        mem_oc: mem_oc_in, good_pin: term_rail_good_out_i};

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin_meta_reg <= '0;
            pin_reg <= '0;
        end
        else
        begin
            pin_meta_reg <= pin_raw;
            pin_reg <= pin_meta_reg;
        end
    end

    // Switching tick divider
    logic [DIV_W-1:0] div_reg;
    logic tick;

    assign tick = (div_reg == DIV_LAST);

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            div_reg <= '0;
        else
            div_reg <= tick ? '0 : div_reg + 1'b1;
    end

    // State, timers, enables and counters
    seq_state_type state_reg, state_next;
    logic [TIMER_W-1:0] timer_reg;
    logic [4:0] en_reg, en_next;
    logic [FCNT_W-1:0] fcnt_reg, fcnt_next;
    logic [FORGIVE_W-1:0] forgive_reg, forgive_next;
    logic cold_reg, cold_next;
    logic hold_reg, sw_clear, good_oe_reg;
    logic [3:0][SS_W-1:0] ramp_reg;
    logic [4:0] mon_ok, fault_evt;
    logic fault_any, ov_evt, bias_ok, start_ok;
    logic timer_done_reset, timer_done_mterm;
    logic [FCNT_W-1:0] fault_sum, fault_limit;
    logic limit_hit;

    assign bias_ok = pin_reg.standby_bias_rail;
    assign start_ok = bias_ok && pin_reg.main_bias_rail && pin_reg.suspend_sleep_in
        && pin_reg.shutdown_sleep_in && !hold_reg;
    assign timer_done_reset = tick && (timer_reg == AMP_RESET_LAST);
    assign timer_done_mterm = tick && (timer_reg == MTERM_LAST);
    assign ov_evt = pin_reg.mem_ov || pin_reg.mterm_ov;

    // Per-rail ramp and fault detection
    genvar r;
    generate
        for (r = 0; r < NUM_RAILS; r++)
        begin : g_rail
            if (r < NUM_RAMPED)
            begin : g_ramp
                always_ff @(posedge sys_clk or negedge rst_b)
                begin
                    if (!rst_b)
                        ramp_reg[r] <= '0;
                    else if (!en_reg[r])
                        ramp_reg[r] <= '0;
                    else if (tick && ramp_reg[r] != RAMP_FULL)
                        ramp_reg[r] <= ramp_reg[r] + 1'b1;
                end
                // Monitor only once the ramp is complete, so a ramping rail is not a UV
                assign mon_ok[r] = en_reg[r] && (ramp_reg[r] == RAMP_FULL);
            end
            else
            begin : g_nramp
                // Armed outside its own settling stage, so a lost input still counts
                assign mon_ok[r] = en_reg[r] && (state_reg != ST_SEQ_MTERM);
            end
            // A cascaded rail losing its input shows its own UV and counts again
            assign fault_evt[r] = mon_ok[r] && ((UV_MON_MASK[r] && pin_reg.uv[r])
                || (r == RAIL_MEM && pin_reg.mem_oc));
        end
    endgenerate

    assign ss_level_out = ramp_reg;
    assign fault_any = |fault_evt;

    always_comb
    begin
        fault_sum = '0;
        for (int i = 0; i < NUM_RAILS; i++)
            fault_sum = fault_sum + FCNT_W'(fault_evt[i]);
    end

    assign fault_limit = cold_reg ? FAULT_LIMIT_COLD : FAULT_LIMIT_RUN;

    // Fault and forgiveness counters; a new fault wins over a software or forgiveness clear, the off-state clear wins over a fault
    always_comb
    begin
        fcnt_next = fcnt_reg;
        forgive_next = forgive_reg;
        if (sw_clear)
            fcnt_next = '0;
        if (fault_any)
        begin
            fcnt_next = fcnt_next + fault_sum;
            forgive_next = '0;
        end
        else if (tick && forgive_reg != FORGIVE_TOP)
        begin
            forgive_next = forgive_reg + 1'b1;
            if (forgive_reg == FORGIVE_LAST)
                fcnt_next = '0;
        end
        if (state_reg == ST_OFF)
        begin
            fcnt_next = '0;
            forgive_next = '0;
        end
    end

    assign limit_hit = fault_any && (fcnt_next >= fault_limit);

    // Sequencer
    always_comb
    begin
        state_next = state_reg;
        en_next = en_reg & ~fault_evt;
        cold_next = cold_reg;
        unique case (state_reg)
            ST_OFF:
            begin
                en_next = '0;
                if (start_ok)
                begin
                    state_next = ST_AMP_RESET;
                    cold_next = 1'b1;
                end
            end
            ST_AMP_RESET:
                if (timer_done_reset)
                    state_next = ST_SEQ_MEM;
            ST_SEQ_MEM:
            begin
                en_next[RAIL_MEM] = 1'b1;
                if (en_reg[RAIL_MEM] && pin_reg.in_reg[RAIL_MEM])
                    state_next = ST_SEQ_CORE;
            end
            ST_SEQ_CORE:
            begin
                en_next[RAIL_CORE] = 1'b1;
                if (en_reg[RAIL_CORE] && pin_reg.in_reg[RAIL_CORE])
                    state_next = ST_SEQ_TERM;
            end
            ST_SEQ_TERM:
            begin
                en_next[RAIL_DAC:RAIL_TERM] = 2'h3;
                if (&en_reg[RAIL_DAC:RAIL_TERM] && &pin_reg.in_reg[RAIL_DAC:RAIL_TERM])
                    state_next = ST_SEQ_MTERM;
            end
            ST_SEQ_MTERM:
            begin
                en_next[RAIL_MTERM] = 1'b1;
                if (timer_done_mterm)
                begin
                    state_next = ST_ACTIVE;
                    cold_next = 1'b0;
                end
            end
            ST_ACTIVE:
                ;
            ST_SUSPEND:
            begin
                en_next = en_next & SUSPEND_KEEP_MASK;
                if (pin_reg.suspend_sleep_in && pin_reg.main_bias_rail)
                    state_next = ST_AMP_RESET;
            end
            ST_LOCKOUT:
                en_next = '0;
        endcase
        // Escapes in rising priority
        if (state_reg != ST_OFF && state_reg != ST_LOCKOUT)
        begin
            if (fault_any && state_reg != ST_SUSPEND && state_reg != ST_AMP_RESET)
                state_next = ST_SEQ_MEM;
            if (!pin_reg.suspend_sleep_in && state_reg != ST_SUSPEND)
            begin
                state_next = ST_SUSPEND;
                en_next = en_next & SUSPEND_KEEP_MASK;
            end
            if (ov_evt || limit_hit)
            begin
                state_next = ST_LOCKOUT;
                en_next = '0;
            end
        end
        if (!bias_ok || !pin_reg.shutdown_sleep_in)
        begin
            // Leaving lockout needs shutdown asserted or standby bias lost, so overvoltage stays latched
            state_next = ST_OFF;
            en_next = '0;
            cold_next = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg <= ST_OFF;
            en_reg <= '0;
            fcnt_reg <= '0;
            forgive_reg <= '0;
            cold_reg <= 1'b0;
            timer_reg <= '0;
            good_oe_reg <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
            en_reg <= en_next;
            fcnt_reg <= fcnt_next;
            forgive_reg <= forgive_next;
            cold_reg <= cold_next;
            timer_reg <= (state_next != state_reg) ? '0 : timer_reg + TIMER_W'(tick);
            good_oe_reg <= !(state_next == ST_ACTIVE && pin_reg.in_reg[RAIL_TERM]);
        end
    end

    // Regulator control outputs
    assign rail_enable_out = en_reg;
    // Memory amplifier left alone when it is already regulating
    assign comp_short_out[0] = (state_reg == ST_AMP_RESET) && !en_reg[RAIL_MEM];
    assign comp_short_out[1] = (state_reg == ST_AMP_RESET);
    assign mterm_ref_short_out = !en_reg[RAIL_MTERM];
    assign term_rail_good_out_o = 1'b0;
    assign term_rail_good_out_oe = good_oe_reg;

    // AHB-Lite slave: zero wait states, always OKAY
    logic addr_take, wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic [31:0] rd_value;
    logic [7:0] a_off;
    logic wr_ctrl;

    assign addr_take = hsel && hready && htrans[1];
    assign a_off = haddr[7:0];
    assign wr_ctrl = wr_pend_reg && (wr_addr_reg == ADDR_CTRL);
    assign sw_clear = wr_ctrl && hwdata[CTRL_CLR_BIT];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_comb
    begin
        rd_value = '0;
        if (haddr[31:8] == '0)
        begin
            if (a_off == ADDR_STATUS)
                rd_value = {16'h0000, 3'h0, pin_reg.good_pin, 3'h0, en_reg, 4'(state_reg)};
            else if (a_off == ADDR_FAULT)
                rd_value = {12'h000, fcnt_reg, 1'b0, forgive_reg};
            else if (a_off == ADDR_CTRL)
                rd_value = {30'h00000000, hold_reg, 1'b0};
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
            hrdata <= '0;
            hold_reg <= CTRL_HOLD_RESET;
        end
        else
        begin
            wr_pend_reg <= addr_take && hwrite;
            wr_addr_reg <= (haddr[31:8] == '0) ? a_off : 8'hFF;
            if (addr_take && !hwrite)
                hrdata <= rd_value;
            if (wr_ctrl)
                hold_reg <= hwdata[CTRL_HOLD_BIT];
        end
    end

endmodule : rail_sequencer

/* sim/rail_plant.sv */
// Regulator power stages and pulled-up good line facing the sequencer
module rail_plant
(
    input wire logic sys_clk,
    input wire logic [4:0] rail_enable_out,
    input wire logic [4:0] uv_force,
    input wire logic good_o,
    input wire logic good_oe,
    output logic [4:0] rail_in_reg_in,
    output logic [4:0] rail_uv_in,
    output logic good_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0][3:0] up_cnt;
    // Outputs settle a few cycles after enable, collapse at once when off
    always_ff @(posedge sys_clk)
        for (int i = 0; i < 5; i++)
            up_cnt[i] <= (!rail_enable_out[i] || uv_force[i]) ? 4'h0 :
                up_cnt[i] + {3'h0, up_cnt[i] != 4'hF};
    always_comb
        for (int i = 0; i < 5; i++)
            rail_in_reg_in[i] = up_cnt[i] >= 4'h6;
    // Memory loss starves the internal termination stage fed from it
    assign rail_uv_in = (uv_force | {!rail_enable_out[0], 4'h0}) & rail_enable_out;
    assign good_pin = good_oe ? good_o : 1'b1;
endmodule : rail_plant

/* sim/rail_sequencer_monitor.sv */
// Port-level assertion checker for the rail sequencer
module rail_sequencer_monitor
    import rail_seq_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES,
    parameter int SS_TICKS = SS_CYCLE_TICKS
)
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic suspend_sleep_in,
    input wire logic shutdown_sleep_in,
    input wire logic mem_ov_in,
    input wire logic [4:0] rail_in_reg_in,
    input wire logic [4:0] rail_enable_out,
    input wire logic [3:0][SS_W-1:0] ss_level_out,
    input wire logic [1:0] comp_short_out,
    input wire logic mterm_ref_short_out,
    input wire logic term_rail_good_out_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int AMP_CYC = AMP_RESET_SS_CYCLES * SS_TICKS * TICK_DIV;
    logic [15:0] short_cnt;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // Tick phase is unknown at entry, so allow one tick either way
    always_ff @(posedge sys_clk or negedge rst_b)
        if (!rst_b)
            short_cnt <= 16'h0000;
        else
            short_cnt <= comp_short_out[1] ? short_cnt + 16'h0001 : 16'h0000;
    a_amp_reset_len: assert property ($fell(comp_short_out[1]) |->
        short_cnt >= AMP_CYC - TICK_DIV && short_cnt <= AMP_CYC + TICK_DIV)
        else $error("amp reset length wrong");
    a_core_after_mem: assert property ($rose(rail_enable_out[1]) |-> rail_enable_out[0])
        else $error("core before memory");
    a_term_with_dac: assert property ($rose(rail_enable_out[4]) |->
        rail_enable_out[2] && rail_enable_out[3])
        else $error("internal before term and dac");
    a_ramp_step: assert property (rail_enable_out[0] && $past(rail_enable_out[0]) |->
        ss_level_out[0] - $past(ss_level_out[0]) <= 11'h001)
        else $error("ramp not monotonic");
    a_mterm_short: assert property (mterm_ref_short_out == !rail_enable_out[4])
        else $error("mterm short wrong");
    a_good_release: assert property ($fell(term_rail_good_out_oe) |->
        rail_enable_out[4] && rail_in_reg_in[2])
        else $error("good released early");
    a_good_idle: assert property (!rail_enable_out[2] && !$past(rail_enable_out[2]) |->
        term_rail_good_out_oe)
        else $error("good not low");
    a_suspend_keep: assert property ($fell(suspend_sleep_in) && shutdown_sleep_in &&
        rail_enable_out[0] |-> ##[2:6] rail_enable_out == SUSPEND_KEEP_MASK)
        else $error("suspend enables wrong");
    a_shutdown_off: assert property (!shutdown_sleep_in [*6] |-> rail_enable_out == 5'h00)
        else $error("shutdown left rails on");
    a_ov_trip: assert property ($rose(mem_ov_in) |->
        ##[1:5] rail_enable_out == 5'h00)
        else $error("overvoltage not tripped");
endmodule : rail_sequencer_monitor

bind rail_sequencer rail_sequencer_monitor #(.TICK_DIV(TICK_DIV), .SS_TICKS(SS_TICKS))
    u_rail_sequencer_monitor (.sys_clk(sys_clk), .rst_b(rst_b),
    .suspend_sleep_in(suspend_sleep_in), .shutdown_sleep_in(shutdown_sleep_in),
    .mem_ov_in(mem_ov_in), .rail_in_reg_in(rail_in_reg_in), .rail_enable_out(rail_enable_out),
    .ss_level_out(ss_level_out), .comp_short_out(comp_short_out),
    .mterm_ref_short_out(mterm_ref_short_out), .term_rail_good_out_oe(term_rail_good_out_oe));

/* sim/rail_sequencer_tb.sv */
// Self-checking bench for the rail sequencer
module rail_sequencer_tb;
    import rail_seq_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DIV = 4;
    localparam int FG = 64;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [2:0] hsize = 3'h2;
    logic suspend_sleep_in = 1'b1;
    logic shutdown_sleep_in = 1'b1;
    logic main_bias_rail = 1'b0;
    logic standby_bias_rail = 1'b1;
    logic mem_ov_in = 1'b0;
    logic [4:0] uv_force = 5'h00;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [4:0] in_reg;
    logic [4:0] uv;
    logic [4:0] en;
    logic [1:0] comp_short;
    logic mterm_short;
    logic good_i;
    logic good_o;
    logic good_oe;
    int fail_count = 0;
    int num_checks = 0;
    always #2 sys_clk = ~sys_clk;

    rail_sequencer #(.TICK_DIV(DIV), .SS_TICKS(8), .FORGIVE_LIMIT(FG)) u_rail_sequencer (
        .sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .suspend_sleep_in(suspend_sleep_in),
        .shutdown_sleep_in(shutdown_sleep_in), .standby_bias_rail(standby_bias_rail),
        .main_bias_rail(main_bias_rail), .rail_in_reg_in(in_reg), .rail_uv_in(uv),
        .mem_ov_in(mem_ov_in), .mterm_ov_in(1'b0), .mem_oc_in(1'b0), .rail_enable_out(en),
        .ss_level_out(), .comp_short_out(comp_short), .mterm_ref_short_out(mterm_short),
        .term_rail_good_out_i(good_i), .term_rail_good_out_o(good_o),
        .term_rail_good_out_oe(good_oe));
    rail_plant u_rail_plant (.sys_clk(sys_clk), .rail_enable_out(en), .uv_force(uv_force),
        .good_o(good_o), .good_oe(good_oe), .rail_in_reg_in(in_reg), .rail_uv_in(uv),
        .good_pin(good_i));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        @(posedge sys_clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb

    task automatic wait_state(input logic [3:0] st, input string what, output logic [31:0] s);
        s = 32'hF;
        for (int n = 0; n < 3000 && s[3:0] !== st; n++)
            ahb(1'b0, ADDR_STATUS, 32'h0, s);
        chk(what, {28'h0, st}, {28'h0, s[3:0]});
    endtask : wait_state

    task automatic t_cold;
        logic [31:0] s;
        repeat (20) @(posedge sys_clk);
        wait_state(4'h0, "idle no 12V", s);
        standby_bias_rail <= 1'b0;
        main_bias_rail <= 1'b1;
        repeat (20) @(posedge sys_clk);
        wait_state(4'h0, "idle no standby", s);
        standby_bias_rail <= 1'b1;
        wait_state(4'h1, "amp reset", s);
        chk("amp short", 32'h3, {30'h0, comp_short});
        wait_state(4'h6, "active", s);
        chk("enables", 32'h1F, {27'h0, s[8:4]});
        ahb(1'b0, ADDR_STATUS, 32'h0, s);
        chk("good pin", 32'h1, {31'h0, s[12]});
        chk("mterm short", 32'h0, {31'h0, mterm_short});
        $display("t_cold done");
    endtask : t_cold

    task automatic t_suspend;
        logic [31:0] s;
        suspend_sleep_in <= 1'b0;
        wait_state(4'h7, "suspend", s);
        chk("suspend enables", 32'h01, {27'h0, s[8:4]});
        chk("good low", 32'h1, {31'h0, good_oe});
        suspend_sleep_in <= 1'b1;
        wait_state(4'h1, "resume reset", s);
        chk("mem kept", 32'h01, {27'h0, s[8:4]});
        chk("core short only", 32'h2, {30'h0, comp_short});
        wait_state(4'h6, "resume active", s);
        $display("t_suspend done");
    endtask : t_suspend

    task automatic t_fault;
        logic [31:0] s;
        // Faults count only once the core ramp has topped out
        repeat (8400) @(posedge sys_clk);
        uv_force <= 5'h02;
        repeat (8) @(posedge sys_clk);
        ahb(1'b0, ADDR_FAULT, 32'h0, s);
        chk("fault count", 32'h1, {28'h0, s[19:16]});
        chk("forgive cleared", 32'h1, {31'h0, s[14:0] <= 15'h0004});
        ahb(1'b0, ADDR_STATUS, 32'h0, s);
        uv_force <= 5'h00;
        chk("others kept", 32'h1D, {27'h0, s[8:4] & 5'h1D});
        wait_state(4'h6, "restart active", s);
        repeat (FG * DIV + 40) @(posedge sys_clk);
        ahb(1'b0, ADDR_FAULT, 32'h0, s);
        chk("forgiven", FG, s);
        // Memory loss starves the internal termination rail: two faults
        uv_force <= 5'h01;
        repeat (8) @(posedge sys_clk);
        ahb(1'b0, ADDR_FAULT, 32'h0, s);
        chk("cascade count", 32'h2, {28'h0, s[19:16]});
        uv_force <= 5'h00;
        wait_state(4'h6, "cascade restart", s);
        $display("t_fault done");
    endtask : t_fault

    task automatic t_ov;
        logic [31:0] s;
        mem_ov_in <= 1'b1;
        wait_state(4'h8, "lockout", s);
        chk("all off", 32'h0, {27'h0, s[8:4]});
        mem_ov_in <= 1'b0;
        repeat (20) @(posedge sys_clk);
        wait_state(4'h8, "latched", s);
        shutdown_sleep_in <= 1'b0;
        wait_state(4'h0, "shutdown", s);
        ahb(1'b1, ADDR_CTRL, 32'h2, s);
        ahb(1'b0, ADDR_FAULT, 32'h0, s);
        chk("fault regs cleared", 32'h0, s);
        shutdown_sleep_in <= 1'b1;
        repeat (20) @(posedge sys_clk);
        wait_state(4'h0, "held off", s);
        ahb(1'b0, 8'h40, 32'h0, s);
        chk("unmapped", 32'h0, s);
        chk("okay resp", 32'h0, {31'h0, hresp});
        ahb(1'b1, ADDR_CTRL, 32'h0, s);
        wait_state(4'h6, "relit", s);
        $display("t_ov done");
    endtask : t_ov

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop

    initial
    begin
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_cold();
        t_suspend();
        t_fault();
        t_ov();
        report_and_stop();
    end

    initial
    begin
        #200000;
        fail_count++;
        report_and_stop();
    end
endmodule : rail_sequencer_tb
